//--- hdl/clock_alarm_pkg.sv
// constants and carrier types for the clock alarm monitor
`default_nettype none
package clock_alarm_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] OFS_ALARM_SUMMARY = 12'h2C0;
	localparam logic [ADDR_W-1:0] OFS_ALARM_LATCHED_FLAGS = 12'h2C1;
	localparam logic [ADDR_W-1:0] OFS_ALARM_SUPPRESS = 12'h2C2;
	localparam int BIT_SUMMARY = 0;
	localparam int BIT_DIVIDER_MISMATCH = 0;
	localparam int BIT_PHASE_REALIGN = 2;
	localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h05;
	localparam logic [DATA_W-1:0] SUPPRESS_RESET = 8'h05;
	localparam logic [DATA_W-1:0] ALARM_BITS = 8'h05;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] flags;
		logic [DATA_W-1:0] suppress;
		logic summary;
		logic stat_pin;
		logic [DATA_W-1:0] rdata;
	} alarm_state_t;
endpackage
`default_nettype wire

//--- hdl/clock_alarm_monitor.sv
// alarm latching, masking and summary logic with its register port
`default_nettype none
module clock_alarm_monitor #(
	parameter int DIV_W = 4
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_soft_reset,
	input wire clock_alarm_pkg::reg_req_t i_reg_req,
	input wire logic i_sync_realign,
	input wire logic [DIV_W-1:0] i_div_phase_a,
	input wire logic [DIV_W-1:0] i_div_phase_b,
	input wire logic i_stat_pin_sel,
	output logic [clock_alarm_pkg::DATA_W-1:0] o_reg_rdata,
	output logic o_alarm_summary,
	output logic o_cal_stat_pin
);
	localparam int DW = clock_alarm_pkg::DATA_W;
	localparam int REALIGN_POS = clock_alarm_pkg::BIT_PHASE_REALIGN;
	localparam int MISMATCH_POS = clock_alarm_pkg::BIT_DIVIDER_MISMATCH;

	if (DIV_W < 1) begin : g_bad_width
		$error("DIV_W must be at least 1");
	end

	// flag positions must sit inside the register and apart from each other
	if (REALIGN_POS >= DW) begin : g_bad_realign_pos
		$error("phase realign flag position outside the register");
	end
	if (MISMATCH_POS >= DW) begin : g_bad_mismatch_pos
		$error("divider mismatch flag position outside the register");
	end
	if (REALIGN_POS == MISMATCH_POS) begin : g_same_pos
		$error("the two alarm flags must sit at different positions");
	end
	if (clock_alarm_pkg::BIT_SUMMARY >= DW) begin : g_bad_summary_pos
		$error("summary bit position outside the register");
	end

	clock_alarm_pkg::alarm_state_t state_ff;
	clock_alarm_pkg::alarm_state_t nxt_state;
	logic [DW-1:0] events;
	logic [DW-1:0] clear_mask;
	logic wr_flags;
	logic wr_suppress;

	always_comb begin
		events = clock_alarm_pkg::ZERO_BYTE;
		events[clock_alarm_pkg::BIT_PHASE_REALIGN] = i_sync_realign;
		events[clock_alarm_pkg::BIT_DIVIDER_MISMATCH] = (i_div_phase_a != i_div_phase_b);
		wr_flags = i_reg_req.wr && (i_reg_req.addr == clock_alarm_pkg::OFS_ALARM_LATCHED_FLAGS);
		wr_suppress = i_reg_req.wr && (i_reg_req.addr == clock_alarm_pkg::OFS_ALARM_SUPPRESS);
		clear_mask = wr_flags ? i_reg_req.wdata : clock_alarm_pkg::ZERO_BYTE;
		nxt_state = state_ff;
		if (i_soft_reset) begin
			nxt_state.flags = clock_alarm_pkg::FLAGS_RESET;
			nxt_state.suppress = clock_alarm_pkg::SUPPRESS_RESET;
		end else begin
			// write-one clears, a same-cycle event wins
			nxt_state.flags = ((state_ff.flags & ~clear_mask) | events)
				& clock_alarm_pkg::ALARM_BITS;
			if (wr_suppress) begin
				nxt_state.suppress = i_reg_req.wdata & clock_alarm_pkg::ALARM_BITS;
			end
		end
		nxt_state.summary = |(nxt_state.flags & ~nxt_state.suppress);
		nxt_state.stat_pin = i_stat_pin_sel && nxt_state.summary;
		// registered read answer, summary register is read-only
		unique case (i_reg_req.addr)
			clock_alarm_pkg::OFS_ALARM_SUMMARY: begin
				nxt_state.rdata = clock_alarm_pkg::ZERO_BYTE;
				nxt_state.rdata[clock_alarm_pkg::BIT_SUMMARY] = state_ff.summary;
			end
			clock_alarm_pkg::OFS_ALARM_LATCHED_FLAGS: begin
				nxt_state.rdata = state_ff.flags;
			end
			clock_alarm_pkg::OFS_ALARM_SUPPRESS: begin
				nxt_state.rdata = state_ff.suppress;
			end
			default: begin
				nxt_state.rdata = clock_alarm_pkg::ZERO_BYTE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff.flags <= clock_alarm_pkg::FLAGS_RESET;
			state_ff.suppress <= clock_alarm_pkg::SUPPRESS_RESET;
			state_ff.summary <= 1'b0;
			state_ff.stat_pin <= 1'b0;
			state_ff.rdata <= clock_alarm_pkg::ZERO_BYTE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign o_reg_rdata = state_ff.rdata;
	assign o_alarm_summary = state_ff.summary;
	assign o_cal_stat_pin = state_ff.stat_pin;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	a_summary_value: assert property (
		o_alarm_summary == |(state_ff.flags & ~state_ff.suppress))
		else $error("summary does not match unsuppressed flags");
	a_summary_readonly: assert property (
		(i_reg_req.addr == clock_alarm_pkg::OFS_ALARM_SUMMARY)
		|=> o_reg_rdata == {{(DW-1){1'b0}}, $past(o_alarm_summary)})
		else $error("summary read returned wrong value");
	a_pin_follows: assert property (
		o_cal_stat_pin == (o_alarm_summary && $past(i_stat_pin_sel)))
		else $error("status pin does not follow selected summary");
	a_realign_sets: assert property (
		i_sync_realign |=> state_ff.flags[clock_alarm_pkg::BIT_PHASE_REALIGN])
		else $error("realign event not latched");
	a_mismatch_sets: assert property (
		(i_div_phase_a != i_div_phase_b) |=> state_ff.flags[clock_alarm_pkg::BIT_DIVIDER_MISMATCH])
		else $error("divider mismatch not latched");
	a_flag_holds: assert property (
		(state_ff.flags[MISMATCH_POS] && !(wr_flags && i_reg_req.wdata[MISMATCH_POS])
		&& !i_soft_reset) |=> state_ff.flags[MISMATCH_POS])
		else $error("flag dropped without write-one");
	a_w1c_clears: assert property (
		(wr_flags && i_reg_req.wdata[REALIGN_POS] && !i_sync_realign && !i_soft_reset)
		|=> !state_ff.flags[REALIGN_POS])
		else $error("write-one did not clear flag");
	a_soft_reset: assert property (
		i_soft_reset |=> state_ff.flags == clock_alarm_pkg::FLAGS_RESET
		##0 state_ff.suppress == clock_alarm_pkg::SUPPRESS_RESET)
		else $error("soft reset did not restore registers");
	a_suppress_write: assert property (
		(wr_suppress && !i_soft_reset)
		|=> state_ff.suppress == ($past(i_reg_req.wdata) & clock_alarm_pkg::ALARM_BITS))
		else $error("suppress register write wrong");
	a_masked_latch: assert property (
		(state_ff.suppress == clock_alarm_pkg::ALARM_BITS && !wr_suppress && !i_soft_reset)
		|=> !o_alarm_summary)
		else $error("suppressed flag reached summary");
	a_set_wins: assert property (
		(i_sync_realign && wr_flags && i_reg_req.wdata[REALIGN_POS])
		|=> state_ff.flags[REALIGN_POS])
		else $error("event lost against clear");

	c_realign_alarm: cover property (
		i_sync_realign && !state_ff.suppress[2] ##1 o_alarm_summary);
	c_clear_flag: cover property (state_ff.flags[0] ##1 !state_ff.flags[0]);
	c_pin_raise: cover property (!o_cal_stat_pin ##1 o_cal_stat_pin);
	c_set_and_clear: cover property (i_sync_realign && wr_flags && i_reg_req.wdata[REALIGN_POS]);
	c_mismatch_alarm: cover property (
		(i_div_phase_a != i_div_phase_b) ##1 state_ff.flags[MISMATCH_POS]);

	// register port answers and pin routing
	a_pin_deselected: assert property (
		!i_stat_pin_sel |=> !o_cal_stat_pin)
		else $error("status pin raised while not selected");
	a_flags_readback: assert property (
		(i_reg_req.addr == clock_alarm_pkg::OFS_ALARM_LATCHED_FLAGS)
		|=> o_reg_rdata == $past(state_ff.flags))
		else $error("flag register read returned wrong value");
	a_suppress_readback: assert property (
		(i_reg_req.addr == clock_alarm_pkg::OFS_ALARM_SUPPRESS)
		|=> o_reg_rdata == $past(state_ff.suppress))
		else $error("suppress register read returned wrong value");
	a_summary_no_write: assert property (
		(i_reg_req.wr && i_reg_req.addr == clock_alarm_pkg::OFS_ALARM_SUMMARY && !i_soft_reset)
		|=> state_ff.suppress == $past(state_ff.suppress))
		else $error("write to summary register changed state");
	a_unmapped_zero: assert property (
		(i_reg_req.addr != clock_alarm_pkg::OFS_ALARM_SUMMARY
		&& i_reg_req.addr != clock_alarm_pkg::OFS_ALARM_LATCHED_FLAGS
		&& i_reg_req.addr != clock_alarm_pkg::OFS_ALARM_SUPPRESS)
		|=> o_reg_rdata == clock_alarm_pkg::ZERO_BYTE)
		else $error("unmapped read returned nonzero data");

	// summary and flag reaction to events, suppressed or not, and to soft reset
	a_realign_raises: assert property (
		(i_sync_realign && !state_ff.suppress[REALIGN_POS] && !wr_suppress && !i_soft_reset)
		|=> o_alarm_summary)
		else $error("unsuppressed realign did not raise summary");
	a_mismatch_raises: assert property (
		((i_div_phase_a != i_div_phase_b) && !state_ff.suppress[MISMATCH_POS]
		&& !wr_suppress && !i_soft_reset) |=> o_alarm_summary)
		else $error("unsuppressed mismatch did not raise summary");
	a_suppressed_latch: assert property (
		(i_sync_realign && state_ff.suppress[REALIGN_POS]) |=> state_ff.flags[REALIGN_POS])
		else $error("suppressed realign not latched");
	a_mismatch_stays: assert property (
		((i_div_phase_a != i_div_phase_b) && wr_flags && i_reg_req.wdata[MISMATCH_POS])
		|=> state_ff.flags[MISMATCH_POS])
		else $error("ongoing mismatch lost against clear");
	a_soft_summary: assert property (
		i_soft_reset |=> !o_alarm_summary)
		else $error("summary raised right after soft reset");

	// per-position checks: implemented alarms latch and hold, reserved positions stay clear
	for (genvar gi = 0; gi < DW; gi++) begin : g_flag_chk
		if (clock_alarm_pkg::ALARM_BITS[gi]) begin : g_alarm
			a_flag_latches: assert property (@(posedge i_clk) disable iff (!i_resetn)
				(state_ff.flags[gi] && !(wr_flags && i_reg_req.wdata[gi]) && !i_soft_reset)
				|=> state_ff.flags[gi])
				else $error("latched flag dropped without write-one");
			a_event_latches: assert property (@(posedge i_clk) disable iff (!i_resetn)
				events[gi] |=> state_ff.flags[gi])
				else $error("alarm event not latched");
			a_flag_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
				(wr_flags && i_reg_req.wdata[gi] && !events[gi] && !i_soft_reset)
				|=> !state_ff.flags[gi])
				else $error("write-one left flag set");
		end else begin : g_reserved
			a_reserved_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
				!state_ff.flags[gi] && !state_ff.suppress[gi])
				else $error("reserved flag or suppress bit set");
		end
	end
endmodule
`default_nettype wire

//--- dv/test_clock_alarm_monitor.sv
// self-checking bench for the clock alarm monitor
`default_nettype none
module test_clock_alarm_monitor;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 0, i_resetn = 0, i_soft_reset = 0, i_sync_realign = 0, i_stat_pin_sel = 0;
	clock_alarm_pkg::reg_req_t i_reg_req = '0;
	logic [3:0] i_div_phase_a = 4'h0, i_div_phase_b = 4'h0;
	logic [7:0] o_reg_rdata;
	logic o_alarm_summary, o_cal_stat_pin;
	int bad_count = 0, checks = 0, cyc = 0;
	clock_alarm_monitor #(.DIV_W(4)) uut (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_soft_reset(i_soft_reset), .i_reg_req(i_reg_req), .i_sync_realign(i_sync_realign),
		.i_div_phase_a(i_div_phase_a), .i_div_phase_b(i_div_phase_b),
		.i_stat_pin_sel(i_stat_pin_sel), .o_reg_rdata(o_reg_rdata),
		.o_alarm_summary(o_alarm_summary), .o_cal_stat_pin(o_cal_stat_pin));
	always #10 i_clk = ~i_clk;
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// the run should need about 60 cycles
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(logic [11:0] a, logic [7:0] e);
		@(posedge i_clk) i_reg_req <= {1'b0, a, 8'h00};
		@(posedge i_clk);
		#1 chk("rdata", e, o_reg_rdata);
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(posedge i_clk) i_reg_req <= {1'b1, a, d};
		@(posedge i_clk) i_reg_req.wr <= 1'b0;
		#1;
	endtask
	// one-cycle realign pulse and/or divider mismatch
	task automatic ev(logic s, logic [3:0] b);
		@(posedge i_clk) {i_sync_realign, i_div_phase_b} <= {s, b};
		@(posedge i_clk) {i_sync_realign, i_div_phase_b} <= 5'h00;
		#1;
	endtask
	task automatic test_reset();
		rd(12'h2C1, 8'h05);
		rd(12'h2C2, 8'h05);
		wr(12'h2C0, 8'hFF);
		rd(12'h2C0, 8'h00);
		rd(12'h123, 8'h00);
		$display("test reset done");
	endtask
	task automatic test_mask();
		wr(12'h2C2, 8'hFF);
		rd(12'h2C2, 8'h05);
		wr(12'h2C2, 8'h00);
		chk("summary", 8'h01, o_alarm_summary);
		chk("pin", 8'h00, o_cal_stat_pin);
		@(posedge i_clk) i_stat_pin_sel <= 1'b1;
		rd(12'h2C0, 8'h01);
		chk("pin", 8'h01, o_cal_stat_pin);
		$display("test mask done");
	endtask
	task automatic test_clear();
		wr(12'h2C1, 8'h01);
		rd(12'h2C1, 8'h04);
		chk("summary", 8'h01, o_alarm_summary);
		wr(12'h2C1, 8'h04);
		rd(12'h2C1, 8'h00);
		chk("pin", 8'h00, o_cal_stat_pin);
		$display("test clear done");
	endtask
	task automatic test_events();
		ev(1'b1, 4'h0);
		chk("pin", 8'h01, o_cal_stat_pin);
		rd(12'h2C1, 8'h04);
		ev(1'b0, 4'h5);
		rd(12'h2C1, 8'h05);
		@(posedge i_clk) {i_reg_req, i_sync_realign} <= {1'b1, 12'h2C1, 8'h05, 1'b1};
		@(posedge i_clk) {i_reg_req.wr, i_sync_realign} <= 2'b00;
		rd(12'h2C1, 8'h04);
		wr(12'h2C1, 8'h04);
		wr(12'h2C2, 8'h04);
		ev(1'b1, 4'h0);
		rd(12'h2C1, 8'h04);
		chk("summary", 8'h00, o_alarm_summary);
		$display("test events done");
	endtask
	task automatic test_soft_reset();
		@(posedge i_clk) i_soft_reset <= 1'b1;
		@(posedge i_clk) i_soft_reset <= 1'b0;
		#1 chk("summary", 8'h00, o_alarm_summary);
		rd(12'h2C1, 8'h05);
		rd(12'h2C2, 8'h05);
		$display("test soft reset done");
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		i_resetn <= 1'b1;
		test_reset();
		test_mask();
		test_clear();
		test_events();
		test_soft_reset();
		conclude();
	end
endmodule
`default_nettype wire
